// ==== hdl/timer_unit.sv ====
// three timer/counters with an ahb-lite register slave
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
module timer_unit
  import timer_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // external pins
  input wire logic timer0_count_input,
  input wire logic timer1_count_input,
  input wire logic timer2_count_input,
  input wire logic ext_irq0_gating_pin,
  input wire logic ext_irq1_gating_pin,
  input wire logic timer2_trigger_pin,
  // interrupt vectoring acknowledges
  input wire logic timer0_irq_ack,
  input wire logic timer1_irq_ack,
  // flags and overflow pulses
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag,
  output logic timer2_irq,
  output logic timer1_overflow_pulse,
  output logic timer2_overflow_pulse
);
  import timer_pkg::*;
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] timer_mode_select;
    logic [3:0] tctrl;
    logic [15:0] t0;
    logic [15:0] t1;
    logic [15:0] t2;
    logic [15:0] rcap;
    logic [7:0] timer2_control;
    logic [1:0] aux;
    logic [3:0] div;
    logic mc_tick;
    bus_state_t bus;
    logic [4:0] addr;
    logic [31:0] rdata;
    logic ready;
    logic irq2;
    logic ovf1;
    logic ovf2;
  } unit_state_t;
  unit_state_t q, d;
  localparam logic [3:0] MC_LAST = 4'(MC_CLOCKS - 1);
  // ----------------------------------------
  // timer 0/1 step for modes 00 to 11
  // ----------------------------------------
  function automatic logic [16:0] step(input tmode_t m, input logic [15:0] v);
    logic [8:0] lo;
    lo = {1'b0, v[7:0]} + 9'h001;
    case (m)
      MODE_13BIT: begin
        if (v[4:0] == 5'h1F) begin
          step = {1'b0, v[15:8], v[7:5], 5'h00} + 17'h00100;
        end else begin
          step = {1'b0, v[15:8], v[7:5], v[4:0] + 5'h01};
        end
      end
      MODE_16BIT: step = {1'b0, v} + 17'h00001;
      MODE_RELOAD8: begin
        if (lo[8]) begin
          step = {1'b1, v[15:8], v[15:8]};
        end else begin
          step = {1'b0, v[15:8], lo[7:0]};
        end
      end
      default: step = {lo[8], v[15:8], lo[7:0]};
    endcase
  endfunction : step
  // ----------------------------------------
  // count sources
  // ----------------------------------------
  logic fall0, fall1, fall2, trig_fall;
  count_edge_sampler u_smp0 (
    .hclk(hclk), .hresetn(hresetn), .sample_en(q.mc_tick),
    .pin(timer0_count_input), .fall_pulse(fall0)
  );
  count_edge_sampler u_smp1 (
    .hclk(hclk), .hresetn(hresetn), .sample_en(q.mc_tick),
    .pin(timer1_count_input), .fall_pulse(fall1)
  );
  count_edge_sampler u_smp2 (
    .hclk(hclk), .hresetn(hresetn), .sample_en(q.mc_tick),
    .pin(timer2_count_input), .fall_pulse(fall2)
  );
  count_edge_sampler u_smpx (
    .hclk(hclk), .hresetn(hresetn), .sample_en(q.mc_tick),
    .pin(timer2_trigger_pin), .fall_pulse(trig_fall)
  );
  tmode_t mode0, mode1;
  logic ev0, ev1, ev2, en0, en1, baud, wr;
  logic wr_timer_mode_select, wr_tctrl, wr_t0, wr_t1, wr_t2, wr_rcap, wr_timer2_control, wr_aux;
  assign mode0 = tmode_t'(q.timer_mode_select[T0_MODE +: 2]);
  assign mode1 = tmode_t'(q.timer_mode_select[T1_MODE +: 2]);
  assign ev0 = q.timer_mode_select[T0_CT] ? fall0 : q.mc_tick;
  assign ev1 = q.timer_mode_select[T1_CT] ? fall1 : q.mc_tick;
  assign ev2 = q.timer2_control[CT2] ? fall2 : q.mc_tick;
  assign en0 = q.tctrl[TR0] & (~q.timer_mode_select[T0_GATE] | ext_irq0_gating_pin);
  assign en1 = q.tctrl[TR1] & (~q.timer_mode_select[T1_GATE] | ext_irq1_gating_pin);
  assign baud = q.timer2_control[RX_CLK] | q.timer2_control[TX_CLK] | q.aux[RX_CLK2] | q.aux[TX_CLK2];
  assign wr = (q.bus == BUS_WRITE);
  assign wr_timer_mode_select = wr && q.addr == OFF_MODE;
  assign wr_tctrl = wr && q.addr == OFF_TCTRL;
  assign wr_t0 = wr && q.addr == OFF_T0;
  assign wr_t1 = wr && q.addr == OFF_T1;
  assign wr_t2 = wr && q.addr == OFF_T2;
  assign wr_rcap = wr && q.addr == OFF_RCAP;
  assign wr_timer2_control = wr && q.addr == OFF_TIMER2_CONTROL;
  assign wr_aux = wr && q.addr == OFF_AUX;
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [16:0] r0, r1;
    logic [8:0] hi0;
    logic ov0, ov1, ovh, ov2, hit;
    d = q;
    r0 = step(mode0, q.t0);
    r1 = step(mode1, q.t1);
    hi0 = {1'b0, q.t0[15:8]} + 9'h001;
    ov0 = 1'b0;
    ov1 = 1'b0;
    ovh = 1'b0;
    ov2 = 1'b0;
    hit = 1'b0;
    // machine-cycle divider
    if (q.div == MC_LAST) begin
      d.div = 4'h0;
      d.mc_tick = 1'b1;
    end else begin
      d.div = q.div + 4'h1;
      d.mc_tick = 1'b0;
    end
    // timer 0
    if (en0 && ev0) begin
      ov0 = r0[16];
      d.t0[7:0] = r0[7:0];
      if (mode0 != MODE_SPLIT) begin
        d.t0[15:8] = r0[15:8];
      end
    end
    if (mode0 == MODE_SPLIT && q.tctrl[TR1] && q.mc_tick) begin
      d.t0[15:8] = hi0[7:0];
      ovh = hi0[8];
    end
    // timer 1, held in its own mode 11
    if (en1 && ev1 && mode1 != MODE_SPLIT) begin
      d.t1 = r1[15:0];
      ov1 = r1[16];
    end
    d.ovf1 = ov1;
    // timer 2
    if (q.timer2_control[TR2] && ev2) begin
      if (q.t2 == 16'hFFFF) begin
        ov2 = 1'b1;
        d.t2 = (baud || !q.timer2_control[CPRL2]) ? q.rcap : 16'h0000;
      end else begin
        d.t2 = q.t2 + 16'h0001;
      end
    end
    d.ovf2 = ov2;
    if (q.timer2_control[TIMER2_EXTERNAL_ENABLE] && trig_fall && !baud) begin
      if (q.timer2_control[CPRL2]) begin
        d.rcap = q.t2;
      end else begin
        d.t2 = q.rcap;
      end
    end
    // software writes, data take priority over counting
    if (wr_timer_mode_select) begin
      d.timer_mode_select = hwdata[7:0];
    end
    if (wr_t0) begin
      d.t0 = hwdata[15:0];
    end
    if (wr_t1) begin
      d.t1 = hwdata[15:0];
    end
    if (wr_t2) begin
      d.t2 = hwdata[15:0];
    end
    if (wr_rcap) begin
      d.rcap = hwdata[15:0];
    end
    if (wr_aux) begin
      d.aux = hwdata[1:0];
    end
    // flags: vectoring clears, software writes, hardware set wins
    if (timer0_irq_ack) begin
      d.tctrl[TF0] = 1'b0;
    end
    if (timer1_irq_ack) begin
      d.tctrl[TF1] = 1'b0;
    end
    if (wr_tctrl) begin
      d.tctrl = hwdata[3:0];
    end
    if (wr_timer2_control) begin
      d.timer2_control = hwdata[7:0];
    end
    if (ov0) begin
      d.tctrl[TF0] = 1'b1;
    end
    if ((ov1 && mode0 != MODE_SPLIT) || ovh) begin
      d.tctrl[TF1] = 1'b1;
    end
    if (ov2 && !baud) begin
      d.timer2_control[TF2] = 1'b1;
    end
    if (q.timer2_control[TIMER2_EXTERNAL_ENABLE] && trig_fall) begin
      d.timer2_control[TIMER2_EXTERNAL_FLAG] = 1'b1;
    end
    d.irq2 = d.timer2_control[TF2] | d.timer2_control[TIMER2_EXTERNAL_FLAG];
    // ahb-lite address phase
    d.ready = 1'b1;
    d.bus = BUS_IDLE;
    if (hsel && htrans[1] && hready) begin
      hit = (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'b00);
      d.addr = hit ? haddr[4:0] : 5'h03;
      d.bus = hwrite ? BUS_WRITE : BUS_IDLE;
      if (!hwrite) begin
        case (d.addr)
          OFF_MODE: d.rdata = {24'h0, q.timer_mode_select};
          OFF_TCTRL: d.rdata = {28'h0, q.tctrl};
          OFF_T0: d.rdata = {16'h0, q.t0};
          OFF_T1: d.rdata = {16'h0, q.t1};
          OFF_T2: d.rdata = {16'h0, q.t2};
          OFF_RCAP: d.rdata = {16'h0, q.rcap};
          OFF_TIMER2_CONTROL: d.rdata = {24'h0, q.timer2_control};
          OFF_AUX: d.rdata = {30'h0, q.aux};
          default: d.rdata = 32'h0;
        endcase
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.timer_mode_select <= MODE_RESET;
      q.t0 <= COUNT_RESET;
      q.t1 <= COUNT_RESET;
      q.t2 <= COUNT_RESET;
      q.rcap <= COUNT_RESET;
      q.timer2_control <= TIMER2_CONTROL_RESET;
      q.bus <= BUS_IDLE;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hreadyout = q.ready;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign timer0_overflow_flag = q.tctrl[TF0];
  assign timer1_overflow_flag = q.tctrl[TF1];
  assign timer2_irq = q.irq2;
  assign timer1_overflow_pulse = q.ovf1;
  assign timer2_overflow_pulse = q.ovf2;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_tick_gap;
    !q.mc_tick [*8] ##1 !q.mc_tick [*3] ##1 q.mc_tick;
  endsequence
  sequence s_t0_mode1_tick;
    q.mc_tick && en0 && !q.timer_mode_select[T0_CT] && mode0 == MODE_16BIT && !wr_t0;
  endsequence
  AST_MC_PERIOD: assert property (q.mc_tick |=> s_tick_gap)
    else $error("machine cycle period is not twelve clocks");
  AST_T0_RATE: assert property (s_t0_mode1_tick |=> q.t0 == $past(q.t0) + 16'h0001)
    else $error("timer 0 did not step once on a machine cycle");
  AST_GATE_HOLD: assert property (q.timer_mode_select[T0_GATE] && !ext_irq0_gating_pin
    && mode0 != MODE_SPLIT && !wr_t0 |=> q.t0 == $past(q.t0))
    else $error("gated timer 0 counted with its pin low");
  AST_CNT_SRC: assert property (q.timer_mode_select[T1_CT] && !fall1 && mode1 != MODE_SPLIT
    && !wr_t1 |=> q.t1 == $past(q.t1))
    else $error("timer 1 counted without a pin event");
  AST_MODE0_CARRY: assert property (en0 && ev0 && mode0 == MODE_13BIT && !wr_t0
    && q.t0[4:0] == 5'h1F |=> q.t0[4:0] == 5'h00
    && q.t0[15:8] == $past(q.t0[15:8]) + 8'h01)
    else $error("13-bit prescaler carry wrong");
  AST_RELOAD8: assert property (en0 && ev0 && mode0 == MODE_RELOAD8 && !wr_t0
    && !wr_tctrl && q.t0[7:0] == 8'hFF |=> q.t0[7:0] == $past(q.t0[15:8])
    && q.tctrl[TF0])
    else $error("8-bit reload or flag missing");
  AST_T1_HOLD: assert property (mode1 == MODE_SPLIT && !wr_t1 |=> $stable(q.t1))
    else $error("timer 1 moved in mode 11");
  AST_SPLIT_HI: assert property (mode0 == MODE_SPLIT && q.tctrl[TR1] && q.mc_tick
    && q.t0[15:8] == 8'hFF && !wr_t0 |=> q.tctrl[TF1] ##1 timer1_overflow_flag)
    else $error("split high byte overflow did not set timer 1 flag");
  AST_T2_CAPTURE: assert property (q.timer2_control[TIMER2_EXTERNAL_ENABLE] && q.timer2_control[CPRL2] && trig_fall
    && !baud && !wr_rcap && !wr_timer2_control |=> q.rcap == $past(q.t2)
    && q.timer2_control[TIMER2_EXTERNAL_FLAG] ##1 timer2_irq)
    else $error("capture or external flag missing");
  AST_T2_RELOAD: assert property (q.timer2_control[TR2] && ev2 && !q.timer2_control[CPRL2]
    && q.t2 == 16'hFFFF && !wr_t2 && !wr_timer2_control && !baud
    |=> q.t2 == $past(q.rcap) && q.timer2_control[TF2])
    else $error("timer 2 rollover did not reload");
  AST_BAUD_NO_TF2: assert property (baud && !q.timer2_control[TF2] && !wr_timer2_control
    |=> !q.timer2_control[TF2])
    else $error("overflow flag set in baud mode");
endmodule : timer_unit

// ==== hdl/timer_pkg.sv ====
// constants and types shared by the three-timer unit
package timer_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_MODE = 5'h00;
  localparam logic [4:0] OFF_TCTRL = 5'h04;
  localparam logic [4:0] OFF_T0 = 5'h08;
  localparam logic [4:0] OFF_T1 = 5'h0C;
  localparam logic [4:0] OFF_T2 = 5'h10;
  localparam logic [4:0] OFF_RCAP = 5'h14;
  localparam logic [4:0] OFF_TIMER2_CONTROL = 5'h18;
  localparam logic [4:0] OFF_AUX = 5'h1C;
  // ----------------------------------------
  // timer_mode_select fields
  // ----------------------------------------
  localparam int T1_GATE = 7;
  localparam int T1_CT = 6;
  localparam int T1_MODE = 4;
  localparam int T0_GATE = 3;
  localparam int T0_CT = 2;
  localparam int T0_MODE = 0;
  // ----------------------------------------
  // run/overflow control fields
  // ----------------------------------------
  localparam int TF1 = 3;
  localparam int TR1 = 2;
  localparam int TF0 = 1;
  localparam int TR0 = 0;
  // ----------------------------------------
  // timer2_control fields
  // ----------------------------------------
  localparam int TF2 = 7;
  localparam int TIMER2_EXTERNAL_FLAG = 6;
  localparam int RX_CLK = 5;
  localparam int TX_CLK = 4;
  localparam int TIMER2_EXTERNAL_ENABLE = 3;
  localparam int TR2 = 2;
  localparam int CT2 = 1;
  localparam int CPRL2 = 0;
  // aux register: second port clock selects
  localparam int RX_CLK2 = 0;
  localparam int TX_CLK2 = 1;
  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] TIMER2_CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam int MC_CLOCKS = 12;
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_SPLIT = 2'b11
  } tmode_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_WRITE = 2'b10
  } bus_state_t;
endpackage : timer_pkg

// ==== hdl/count_edge_sampler.sv ====
// per-machine-cycle sampler that flags a high-then-low pin sequence
`timescale 1ns/100ps
module count_edge_sampler (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // sampling
  input wire logic sample_en,
  input wire logic pin,
  output logic fall_pulse
);
  typedef struct packed {
    logic last;
    logic pulse;
  } smp_state_t;
  smp_state_t q, d;
  always_comb begin
    d = q;
    d.pulse = 1'b0;
    if (sample_en) begin
      d.last = pin;
      d.pulse = q.last & ~pin;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign fall_pulse = q.pulse;
endmodule : count_edge_sampler

// ==== tb/event_pin_source.sv ====
// far-side model driving the count and trigger pins
`timescale 1ns/100ps
module event_pin_source (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // commands from the bench
  input wire logic burst_go,
  input wire logic [7:0] burst_len,
  input wire logic [7:0] half_cyc,
  input wire logic trig_level,
  // pins and status
  output logic count_pin,
  output logic trigger_pin,
  output logic burst_busy
);
  logic [7:0] left_reg;
  logic [7:0] hold_reg;
  logic [7:0] half_reg;
  // each level stands half_cyc clocks, ends low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_pin <= 1'b0;
      trigger_pin <= 1'b0;
      burst_busy <= 1'b0;
      left_reg <= 8'h00;
      hold_reg <= 8'h00;
      half_reg <= 8'h00;
    end else begin
      trigger_pin <= trig_level;
      if (burst_go && !burst_busy) begin
        burst_busy <= 1'b1;
        left_reg <= burst_len;
        half_reg <= half_cyc;
        hold_reg <= half_cyc;
        count_pin <= 1'b1;
      end else if (burst_busy) begin
        if (hold_reg != 8'h01) begin
          hold_reg <= hold_reg - 8'h01;
        end else if (count_pin) begin
          count_pin <= 1'b0;
          hold_reg <= half_reg;
        end else if (left_reg != 8'h01) begin
          count_pin <= 1'b1;
          left_reg <= left_reg - 8'h01;
          hold_reg <= half_reg;
        end else begin
          burst_busy <= 1'b0;
        end
      end
    end
  end
endmodule : event_pin_source

// ==== tb/classic_three_timer_counter_unit_tb_top.sv ====
// self-checking bench for the three-timer unit
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module classic_three_timer_counter_unit_tb_top;
  import timer_pkg::*;
  logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, d, seed = 32'h58;
  logic [1:0] htrans = 2'b00, m0, m1;
  logic gate0 = 1'b0, gate1 = 1'b0, ack0 = 1'b0, ack1 = 1'b0, trig_level = 1'b1;
  logic burst_go = 1'b0, cpin, tpin, busy, f0, f1, irq2, p1o, p2o, f0_q, f1_q, i2_q;
  logic [7:0] burst_len = 8'h01, half_cyc = 8'h0C;
  logic [7:0] t2v [6] = '{8'h01, 8'h00, 8'h21, 8'h11, 8'h01, 8'h01};
  logic [16:0] t;
  logic [15:0] s0, s1, e0, e1;
  int compares = 0, miscompares = 0, cycles = 0, rise0 = 0, rise1 = 0, irq_rise = 0;
  int t1p = 0, t2p = 0, i, j, k, o0, o1, p1, c0, c1, cp;
  assign hready = hreadyout;
  timer_unit timer_unit_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer0_count_input(cpin),
    .timer1_count_input(cpin), .timer2_count_input(cpin), .ext_irq0_gating_pin(gate0),
    .ext_irq1_gating_pin(gate1), .timer2_trigger_pin(tpin), .timer0_irq_ack(ack0),
    .timer1_irq_ack(ack1), .timer0_overflow_flag(f0), .timer1_overflow_flag(f1),
    .timer2_irq(irq2), .timer1_overflow_pulse(p1o), .timer2_overflow_pulse(p2o));
  event_pin_source event_pin_source_inst (.hclk(hclk), .hresetn(hresetn),
    .burst_go(burst_go), .burst_len(burst_len), .half_cyc(half_cyc),
    .trig_level(trig_level), .count_pin(cpin), .trigger_pin(tpin), .burst_busy(busy));
  // ----------------------------------------
  // clock, monitors, timeout
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    rise0 += (f0 === 1'b1 && f0_q !== 1'b1);
    rise1 += (f1 === 1'b1 && f1_q !== 1'b1);
    irq_rise += (irq2 === 1'b1 && i2_q !== 1'b1);
    t1p += (p1o === 1'b1);
    t2p += (p2o === 1'b1);
    f0_q <= f0;
    f1_q <= f1;
    i2_q <= irq2;
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      complete_run();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // one machine-cycle step: {overflow, next count}
  function automatic logic [16:0] step(input logic [1:0] m, input logic [15:0] v);
    logic [12:0] c;
    c = {v[15:8], v[4:0]} + 13'h1;
    case (m)
      2'h0: return {c == 13'h0, c[12:5], v[7:5], c[4:0]};
      2'h1: return {v == 16'hFFFF, v + 16'h1};
      2'h2: return (v[7:0] == 8'hFF) ? {1'b1, v[15:8], v[15:8]} : {1'b0, v[15:8], v[7:0] + 8'h1};
      default: return {v[7:0] == 8'hFF, v[15:8], v[7:0] + 8'h1};
    endcase
  endfunction : step
  task automatic bus_xfer(input logic [4:0] a, input logic wr, input logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {27'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= v;
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask : bus_xfer
  task automatic burst(input logic [7:0] n, input logic [7:0] h);
    burst_len <= n;
    half_cyc <= h;
    burst_go <= 1'b1;
    @(posedge hclk);
    burst_go <= 1'b0;
    do @(posedge hclk); while (busy === 1'b1);
    repeat (30) @(posedge hclk);
  endtask : burst
  task automatic trig_fall();
    trig_level <= 1'b0;
    repeat (40) @(posedge hclk);
    trig_level <= 1'b1;
    repeat (40) @(posedge hclk);
  endtask : trig_fall
  task complete_run();
    $display("comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    bus_xfer(OFF_MODE, 1'b0, 32'h0);
    `CHK(d[7:0], MODE_RESET)
    bus_xfer(OFF_TIMER2_CONTROL, 1'b0, 32'h0);
    `CHK(d[7:0], TIMER2_CONTROL_RESET)
    bus_xfer(5'h06, 1'b1, 32'hF);
    bus_xfer(5'h02, 1'b0, 32'h0);
    `CHK(d, 32'h0)
    bus_xfer(OFF_TCTRL, 1'b0, 32'h0);
    `CHK({hresp, d[3:0]}, 5'h00)
    for (i = 0; i < 16; i++) begin
      m0 = i[1:0];
      m1 = i[3:2];
      r = xs();
      s0 = {8'hFF, 8'hE0 | r[7:0]};
      s1 = {8'hFF, 8'hE0 | r[15:8]};
      k = int'(r[20:16]) + 1;
      e0 = s0;
      e1 = s1;
      o0 = 0;
      o1 = 0;
      p1 = 0;
      for (j = 0; j < k; j++) begin
        t = step(m0, e0);
        e0 = t[15:0];
        o0 += t[16];
        if (m0 == 2'h3) begin
          o1 += (e0[15:8] == 8'hFF);
          e0[15:8] = e0[15:8] + 8'h1;
        end
        if (m1 != 2'h3) begin
          t = step(m1, e1);
          e1 = t[15:0];
          p1 += t[16];
          if (m0 != 2'h3) o1 += t[16];
        end
      end
      bus_xfer(OFF_MODE, 1'b1, {26'h0, m1, 2'b00, m0});
      bus_xfer(OFF_T0, 1'b1, {16'h0, s0});
      bus_xfer(OFF_T1, 1'b1, {16'h0, s1});
      c0 = rise0;
      c1 = rise1;
      cp = t1p;
      bus_xfer(OFF_TCTRL, 1'b1, 32'h5);
      repeat (12 * k - 3) @(posedge hclk);
      bus_xfer(OFF_TCTRL, 1'b1, 32'h0);
      bus_xfer(OFF_T0, 1'b0, 32'h0);
      `CHK(d[15:0], e0)
      bus_xfer(OFF_T1, 1'b0, 32'h0);
      `CHK(d[15:0], e1)
      `CHK(rise0 - c0, int'(o0 != 0))
      `CHK(rise1 - c1, int'(o1 != 0))
      `CHK(t1p - cp, p1)
    end
    bus_xfer(OFF_MODE, 1'b1, 32'h11);
    bus_xfer(OFF_T0, 1'b1, 32'hFFFF);
    bus_xfer(OFF_T1, 1'b1, 32'hFFFF);
    bus_xfer(OFF_TCTRL, 1'b1, 32'h5);
    repeat (30) @(posedge hclk);
    `CHK({f1, f0}, 2'b11)
    ack0 <= 1'b1;
    ack1 <= 1'b1;
    @(posedge hclk);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    repeat (2) @(posedge hclk);
    `CHK({f1, f0}, 2'b00)
    for (i = 0; i < 6; i++) begin
      r = xs();
      bus_xfer(OFF_AUX, 1'b1, (i > 3) ? i - 3 : 0);
      bus_xfer(OFF_RCAP, 1'b1, {16'h0, r[15:0]});
      bus_xfer(OFF_T2, 1'b1, 32'hFFFE);
      bus_xfer(OFF_TIMER2_CONTROL, 1'b1, {24'h0, t2v[i]});
      c0 = irq_rise;
      cp = t2p;
      bus_xfer(OFF_TIMER2_CONTROL, 1'b1, {24'h0, t2v[i] | 8'h04});
      repeat (237) @(posedge hclk);
      `CHK(irq2, 1'(i < 2))
      bus_xfer(OFF_TIMER2_CONTROL, 1'b1, {24'h0, t2v[i]});
      bus_xfer(OFF_T2, 1'b0, 32'h0);
      `CHK(d[15:0], (i == 0) ? 16'h0012 : r[15:0] + 16'h0012)
      `CHK(t2p - cp, 1)
      `CHK(irq_rise - c0, int'(i < 2))
    end
    bus_xfer(OFF_AUX, 1'b1, 32'h0);
    r = xs();
    bus_xfer(OFF_TIMER2_CONTROL, 1'b1, 32'h09);
    bus_xfer(OFF_T2, 1'b1, {16'h0, r[15:0]});
    trig_fall();
    bus_xfer(OFF_RCAP, 1'b0, 32'h0);
    `CHK(d[15:0], r[15:0])
    bus_xfer(OFF_TIMER2_CONTROL, 1'b0, 32'h0);
    `CHK({irq2, d[7:0]}, 9'h149)
    bus_xfer(OFF_TIMER2_CONTROL, 1'b1, 32'h08);
    bus_xfer(OFF_RCAP, 1'b1, {16'h0, r[31:16]});
    trig_fall();
    bus_xfer(OFF_T2, 1'b0, 32'h0);
    `CHK(d[15:0], r[31:16])
    bus_xfer(OFF_TIMER2_CONTROL, 1'b0, 32'h0);
    `CHK(d[7:0], 8'h48)
    bus_xfer(OFF_MODE, 1'b1, 32'hDD);
    bus_xfer(OFF_T0, 1'b1, 32'h0);
    bus_xfer(OFF_T1, 1'b1, 32'h0);
    bus_xfer(OFF_T2, 1'b1, 32'h0);
    bus_xfer(OFF_TIMER2_CONTROL, 1'b1, 32'h07);
    gate0 <= 1'b1;
    gate1 <= 1'b1;
    burst(8'h04, 8'h0C);
    burst(8'h03, 8'h1E);
    gate0 <= 1'b0;
    gate1 <= 1'b0;
    burst(8'h02, 8'h18);
    bus_xfer(OFF_T0, 1'b0, 32'h0);
    `CHK(d[15:0], 16'h0007)
    bus_xfer(OFF_T1, 1'b0, 32'h0);
    `CHK(d[15:0], 16'h0007)
    bus_xfer(OFF_T2, 1'b0, 32'h0);
    `CHK(d[15:0], 16'h0009)
    complete_run();
  end
endmodule : classic_three_timer_counter_unit_tb_top
